//--- pcrc_pkg.sv
/*
 * Package of the parallel CRC engine: register offsets, field positions,
 * reset values and the two generator polynomials.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package pcrc_pkg;

    // =========================================================================
    // Register map (byte addresses).
    // =========================================================================
    localparam logic [11:0] PCRC_CTRL_OFS = 12'h000;
    localparam logic [11:0] PCRC_PRESET_OFS = 12'h004;
    localparam logic [11:0] PCRC_DATA_OFS = 12'h008;
    localparam logic [11:0] PCRC_RESULT_OFS = 12'h00C;
    localparam logic [11:0] PCRC_STATUS_OFS = 12'h010;

    // =========================================================================
    // Control register fields.
    // =========================================================================
    localparam int PCRC_CTRL_MODE_BIT = 0;
    localparam int PCRC_CTRL_MSB_BIT = 1;
    localparam int PCRC_CTRL_REV_BIT = 2;
    localparam int PCRC_CTRL_WIDTH_LSB = 3;
    localparam int PCRC_CTRL_INIT_BIT = 8;
    localparam logic [4:0] PCRC_CTRL_RESET = 5'h00;

    // =========================================================================
    // Data widths, preset and polynomials.
    // =========================================================================
    localparam logic [1:0] PCRC_WIDTH_8 = 2'h0;
    localparam logic [1:0] PCRC_WIDTH_16 = 2'h1;
    localparam logic [1:0] PCRC_WIDTH_32 = 2'h2;
    localparam logic [31:0] PCRC_PRESET_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] PCRC_POLY32 = 32'h04C11DB7;
    localparam logic [15:0] PCRC_POLY16 = 16'h1021;

    typedef enum logic [1:0] {
        PCRC_IDLE = 2'b00,
        PCRC_CALC = 2'b01
    } pcrc_state_t;

endpackage

//--- pcrc_if.sv
/*
 * Interface carrying one data word from the register side to the
 * checksum datapath and the updated remainder back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface pcrc_if;
    logic [31:0] crc_in;
    logic [31:0] data;
    logic [1:0] width;
    logic mode32;
    logic msb_first;
    logic [31:0] crc_out;

    modport ctrl (output crc_in, output data, output width, output mode32,
                  output msb_first, input crc_out);
    modport core (input crc_in, input data, input width, input mode32,
                  input msb_first, output crc_out);
endinterface

//--- pcrc_core.sv
/*
 * Combinational next-remainder of one data word, 8/16/32 bits wide,
 * for the 16-bit or the 32-bit polynomial, LSB or MSB first.
 * Assumes the caller registers the result.
 */
`timescale 1ns/100ps
module pcrc_core
    import pcrc_pkg::*;
(
    pcrc_if.core bus
);

    // =========================================================================
    // Bit-serial division unrolled into one cycle.
    // =========================================================================
    // The remainder sits left-aligned in 32 bits so both polynomials share
    // one loop; the 16-bit case uses the upper half.
    always_comb
    begin
        logic [31:0] r;
        logic [31:0] poly;
        logic [5:0] nbits;
        logic din;
        logic fb;
        nbits = 6'd32;
        din = 1'b0;
        fb = 1'b0;
        r = bus.mode32 ? bus.crc_in : {bus.crc_in[15:0], 16'h0000};
        poly = bus.mode32 ? PCRC_POLY32 : {PCRC_POLY16, 16'h0000};
        unique case (bus.width)
            PCRC_WIDTH_8: nbits = 6'd8;
            PCRC_WIDTH_16: nbits = 6'd16;
            default: nbits = 6'd32;
        endcase
        for (int i = 0; i < 32; i++)
        begin
            if (i < int'(nbits))
            begin
                din = bus.msb_first ? bus.data[int'(nbits) - 1 - i] : bus.data[i];
                fb = r[31] ^ din;
                r = {r[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
            end
        end
        bus.crc_out = bus.mode32 ? r : {16'h0000, r[31:16]};
    end

endmodule // pcrc_core

//--- pcrc_top.sv
/*
 * Parallel CRC16/CRC32 engine with an AHB-Lite register slave.
 * Assumes a single AHB-Lite master, single word transfers, one clock.
 */
// What this block does
// - Checksum width is chosen by configuration, 16 or 32 bits.
// - 16-bit mode divides by x^16 + x^12 + x^5 + 1.
// - 32-bit mode uses the Ethernet polynomial.
// - Each whole input word updates the checksum in a single clock cycle.
// - The raw remainder is the result, with no final inversion.
// - Software programs the preset the checksum starts from.
// - Words are processed either LSB first or MSB first.
// - 32-bit mode takes 32, 16 or 8 bit words, exactly that many bits.
// - 16-bit mode takes 32, 16 or 8 bit words, exactly that many bits.
// - An option mirrors data and result for reflected conventions.
`timescale 1ns/100ps
module pcrc_top
    import pcrc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // =========================================================================
    // Registers.
    // =========================================================================
    logic [4:0] ctrl_reg;
    logic [31:0] preset_reg;
    logic [31:0] crc_reg;
    logic [31:0] word_count_reg;
    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] hwdata_rev;
    logic [31:0] data_mirror;
    logic [31:0] crc_rev;
    logic [31:0] crc_mirror;
    logic [31:0] result_view;
    logic addr_valid;
    logic ctrl_wr;
    logic preset_wr;
    logic data_wr;
    logic init_wr;
    logic [4:0] ctrl_view;
    logic [31:0] preset_view;
    logic [31:0] crc_view;
    logic [31:0] count_view;
    pcrc_if cif ();

    assign addr_valid = hsel & htrans[1] & hready;

    // =========================================================================
    // Write strobes of the data phase in flight.
    // =========================================================================
    assign ctrl_wr = wr_pend_reg & (wr_addr_reg == PCRC_CTRL_OFS);
    assign preset_wr = wr_pend_reg & (wr_addr_reg == PCRC_PRESET_OFS);
    assign data_wr = wr_pend_reg & (wr_addr_reg == PCRC_DATA_OFS);
    assign init_wr = ctrl_wr & hwdata[PCRC_CTRL_INIT_BIT];

    // =========================================================================
    // Datapath hookup.
    // =========================================================================
    // Reversal mirrors the incoming word before division and the stored
    // remainder on the way out, so the state itself is never mirrored.
    // Both words are mirrored across all 32 bits; a narrower view is the
    // upper slice, which holds the mirrored low bits.
    generate
        for (genvar gi = 0; gi < 32; gi++)
        begin : g_mirror
            assign hwdata_rev[gi] = hwdata[31 - gi];
            assign crc_rev[gi] = crc_view[31 - gi];
        end
    endgenerate

    always_comb
    begin
        unique case (ctrl_reg[PCRC_CTRL_WIDTH_LSB +: 2])
            PCRC_WIDTH_8: data_mirror = {24'h000000, hwdata_rev[31:24]};
            PCRC_WIDTH_16: data_mirror = {16'h0000, hwdata_rev[31:16]};
            default: data_mirror = hwdata_rev;
        endcase
    end

    assign cif.crc_in = crc_reg;
    assign cif.data = ctrl_reg[PCRC_CTRL_REV_BIT] ? data_mirror : hwdata;
    assign cif.width = ctrl_reg[PCRC_CTRL_WIDTH_LSB +: 2];
    assign cif.mode32 = ctrl_reg[PCRC_CTRL_MODE_BIT];
    assign cif.msb_first = ctrl_reg[PCRC_CTRL_MSB_BIT];

    pcrc_core u_core (
        .bus(cif.core)
    );

    // =========================================================================
    // State once the write in flight has landed.
    // =========================================================================
    // A read whose address phase overlaps a write's data phase must see the
    // written value; reading the registers alone would return stale data.
    assign ctrl_view = ctrl_wr ? hwdata[4:0] : ctrl_reg;
    assign preset_view = preset_wr ? hwdata : preset_reg;
    assign crc_view = init_wr ? preset_reg : (data_wr ? cif.crc_out : crc_reg);
    assign count_view = init_wr ? 32'h00000000 :
        (data_wr ? word_count_reg + 32'h00000001 : word_count_reg);

    assign crc_mirror = ctrl_view[PCRC_CTRL_MODE_BIT] ? crc_rev : {16'h0000, crc_rev[31:16]};
    assign result_view = ctrl_view[PCRC_CTRL_REV_BIT] ? crc_mirror :
        (ctrl_view[PCRC_CTRL_MODE_BIT] ? crc_view : {16'h0000, crc_view[15:0]});

    // =========================================================================
    // AHB-Lite address phase capture.
    // =========================================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend_reg <= addr_valid & hwrite;
            wr_addr_reg <= haddr[11:0];
        end
    end

    // =========================================================================
    // Register writes in the data phase.
    // =========================================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= PCRC_CTRL_RESET;
            preset_reg <= PCRC_PRESET_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_view;
            preset_reg <= preset_view;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            crc_reg <= PCRC_PRESET_RESET;
            word_count_reg <= 32'h00000000;
        end
        else
        begin
            crc_reg <= crc_view;
            word_count_reg <= count_view;
        end
    end

    // =========================================================================
    // Read data, registered one cycle after the address phase.
    // =========================================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_reg <= 32'h00000000;
        end
        else if (addr_valid & ~hwrite)
        begin
            unique case (haddr[11:0])
                PCRC_CTRL_OFS: hrdata_reg <= {27'h0000000, ctrl_view};
                PCRC_PRESET_OFS: hrdata_reg <= preset_view;
                PCRC_RESULT_OFS: hrdata_reg <= result_view;
                PCRC_STATUS_OFS: hrdata_reg <= count_view;
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Zero-wait-state slave: every transfer completes in one data phase.
    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule // pcrc_top

//--- pcrc_top_assertions.sv
/* Bus-side checker of the parallel CRC engine.
   Sees only the top module's ports and is bound into pcrc_top. */
`timescale 1ns/100ps
module pcrc_top_assertions
    import pcrc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic ph_v, ph_w, fresh;
    logic [11:0] ph_a;
    logic [31:0] pre_q, cnt_q;
    logic [4:0] ctl_q;
    wire rd = ph_v & ~ph_w;
    wire wr = ph_v & ph_w;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // =====================================================================
    // Shadow of the data phase and of the software-visible state.
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) {ph_v, ph_w, ph_a} <= '0;
        else {ph_v, ph_w, ph_a} <= {hsel & htrans[1] & hready, hwrite, haddr[11:0]};
    end
    // Fresh means the remainder still equals the preset, so a read can be predicted.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) {pre_q, cnt_q, ctl_q, fresh} <= {PCRC_PRESET_RESET, 32'h0, 5'h0, 1'b1};
        else if (wr && ph_a == PCRC_PRESET_OFS) {pre_q, fresh} <= {hwdata, 1'b0};
        else if (wr && ph_a == PCRC_DATA_OFS) {cnt_q, fresh} <= {cnt_q + 32'h1, 1'b0};
        else if (wr && ph_a == PCRC_CTRL_OFS)
        begin
            ctl_q <= hwdata[4:0];
            if (hwdata[8]) {cnt_q, fresh} <= {32'h0, 1'b1};
        end
    end
    // =====================================================================
    // Properties.
    // =====================================================================
    AST_READY: assert property (hreadyout) else $error("hreadyout low");
    AST_OKAY: assert property (hresp == 1'b0) else $error("error response");
    AST_DATA_RD: assert property (rd && ph_a == PCRC_DATA_OFS |-> hrdata == 32'h0)
        else $error("data port read not zero");
    AST_UNMAPPED: assert property (rd && ph_a > PCRC_STATUS_OFS |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_RB: assert property (rd && ph_a == PCRC_CTRL_OFS |-> hrdata == {27'h0, ctl_q})
        else $error("control readback wrong");
    AST_PRESET_RB: assert property (rd && ph_a == PCRC_PRESET_OFS |-> hrdata == pre_q)
        else $error("preset readback wrong");
    AST_COUNT: assert property (rd && ph_a == PCRC_STATUS_OFS |-> hrdata == cnt_q)
        else $error("word count wrong");
    AST_INIT_LOAD: assert property (rd && ph_a == PCRC_RESULT_OFS && fresh && ctl_q[0]
        && !ctl_q[2] |-> hrdata == pre_q) else $error("init did not load preset");
    cover property (rd && ph_a == PCRC_RESULT_OFS && !fresh);
    cover property (wr && ph_a == PCRC_DATA_OFS);
    cover property (wr && ph_a == PCRC_CTRL_OFS && hwdata[8]);
endmodule // pcrc_top_assertions

bind pcrc_top pcrc_top_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

//--- pcrc_top_bench.sv
/* Self-checking testbench of the parallel CRC engine over AHB-Lite.
   Assumes one slave whose hreadyout is the bus hready. */
`timescale 1ns/100ps
module pcrc_top_bench import pcrc_pkg::*;;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp;
    int errors = 0, total_checks = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    pcrc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    // =====================================================================
    // Bus tasks and reference model.
    // =====================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        {htrans, hwdata} <= {2'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    // Bit-serial division; the engine must match it for a whole word per cycle.
    function automatic logic [31:0] step(logic [4:0] c, logic [31:0] r, logic [31:0] d);
        int n;
        logic [31:0] x;
        logic fb;
        n = 8 << c[4:3];
        x = d;
        if (c[2]) for (int i = 0; i < n; i++) x[i] = d[n-1-i];
        for (int i = 0; i < n; i++)
        begin
            fb = (c[0] ? r[31] : r[15]) ^ (c[1] ? x[n-1-i] : x[i]);
            r = (r << 1) ^ (fb ? (c[0] ? PCRC_POLY32 : {16'h0, PCRC_POLY16}) : 32'h0);
        end
        return c[0] ? r : {16'h0, r[15:0]};
    endfunction
    function automatic logic [31:0] view(logic [4:0] c, logic [31:0] r);
        logic [31:0] m;
        m = r;
        if (c[2]) for (int i = 0; i < 32; i++) m[i] = c[0] ? r[31-i] : (i < 16 ? r[15-i] : 1'b0);
        return m;
    endfunction
    // =====================================================================
    // Scenarios.
    // =====================================================================
    task automatic t_regs;
        rdc(PCRC_CTRL_OFS, 32'h0);
        rdc(PCRC_PRESET_OFS, PCRC_PRESET_RESET);
        rdc(PCRC_STATUS_OFS, 32'h0);
        rdc(PCRC_RESULT_OFS, {16'h0000, PCRC_PRESET_RESET[15:0]});
        rdc(PCRC_DATA_OFS, 32'h0);
        rdc(12'h020, 32'h0);
        wr(PCRC_PRESET_OFS, 32'h5A5A0FF0);
        rdc(PCRC_PRESET_OFS, 32'h5A5A0FF0);
        $display("test regs done");
    endtask
    // Standard check strings pin the engine to the published polynomials.
    task automatic t_known;
        for (int m = 0; m < 2; m++)
        begin
            wr(PCRC_PRESET_OFS, 32'hFFFFFFFF);
            wr(PCRC_CTRL_OFS, 32'h102 | m);
            for (int i = 0; i < 9; i++) wr(PCRC_DATA_OFS, 32'hFFFFFF31 + i);
            rdc(PCRC_RESULT_OFS, m ? 32'h0376E6E7 : 32'h000029B1);
        end
        $display("test known done");
    endtask
    task automatic t_calc;
        logic [4:0] c;
        logic [31:0] p, e;
        for (int k = 0; k < 24; k++)
        begin
            c = k[4:0];
            p = 32'hC3A50F1D + k;
            wr(PCRC_PRESET_OFS, p);
            wr(PCRC_CTRL_OFS, 32'h100 | c);
            e = c[0] ? p : {16'h0, p[15:0]};
            rdc(PCRC_RESULT_OFS, view(c, e));
            wr(PCRC_DATA_OFS, 32'h8C3BE179 ^ k);
            e = step(c, e, 32'h8C3BE179 ^ k);
            wr(PCRC_DATA_OFS, 32'h01234567 << k);
            e = step(c, e, 32'h01234567 << k);
            rdc(PCRC_RESULT_OFS, view(c, e));
            rdc(PCRC_STATUS_OFS, 32'h2);
            rdc(PCRC_CTRL_OFS, {27'h0, c});
        end
        $display("test calc done");
    endtask
    // A reset in mid-run must bring every register back to its reset value.
    task automatic t_reset;
        wr(PCRC_PRESET_OFS, 32'h12345678);
        wr(PCRC_CTRL_OFS, 32'h115);
        wr(PCRC_DATA_OFS, 32'hA5A5A5A5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(PCRC_CTRL_OFS, 32'h0);
        rdc(PCRC_PRESET_OFS, PCRC_PRESET_RESET);
        rdc(PCRC_RESULT_OFS, {16'h0000, PCRC_PRESET_RESET[15:0]});
        rdc(PCRC_STATUS_OFS, 32'h0);
        $display("test reset done");
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_known();
        t_calc();
        t_reset();
        print_verdict();
    end
    initial
    begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule // pcrc_top_bench
